// ---- hdl/lsc_defs.svh ----
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH

`define LSC_ARCH_REV_MISALIGN 3'h2
`define LSC_LEN_WORD          3'h3
`define LSC_LEN_DOUBLE        3'h7
`define LSC_LANE_LAST         4'h7
`define LSC_SEG_UNMAPPED      2'h2
`define LSC_UNIT_SYSCTL       2'h0
`define LSC_EXC_NONE          2'h0
`define LSC_EXC_XLATE         2'h1
`define LSC_EXC_MISALIGN      2'h2
`define LSC_EXC_UNIT          2'h3
`define LSC_ALL_LANES         8'hFF

`endif

// ---- hdl/lsc_pkg.sv ----
package lsc_pkg;

   typedef logic [24:0] lsc_func_t;

   typedef enum logic [2:0] {
      LSC_OP_LOAD  = 3'h0,
      LSC_OP_STORE = 3'h1,
      LSC_OP_CLW   = 3'h2,
      LSC_OP_CLD   = 3'h3,
      LSC_OP_CSW   = 3'h4,
      LSC_OP_CSD   = 3'h5,
      LSC_OP_FUN   = 3'h6
   } lsc_op_t;

   typedef enum logic [2:0] {
      LSC_ST_IDLE   = 3'h0,
      LSC_ST_COPGET = 3'h1,
      LSC_ST_MEMACC = 3'h3,
      LSC_ST_COPPUT = 3'h2,
      LSC_ST_DONE   = 3'h6
   } lsc_fsm_t;

   typedef struct packed {
      lsc_fsm_t    fsm;
      lsc_op_t     op;
      logic [1:0]  unit;
      logic [4:0]  target;
      logic [2:0]  len;
      logic [2:0]  sh;
      logic [7:0]  lanes;
      logic [31:0] paddr;
      logic        cached;
      logic        fetch;
      logic [63:0] wdata;
      logic        mem_req;
      logic        mem_wr;
      logic        cop_req;
      lsc_op_t     cop_kind;
      logic [63:0] cop_wdata;
      lsc_func_t   func;
      logic        done;
      logic [63:0] rdata;
      logic [7:0]  rmask;
      logic [1:0]  exc;
      logic        mis_ok;
   } lsc_dev_state_t;

   typedef struct packed {
      logic        mem_ack;
      logic [63:0] mem_rdata;
      logic [7:0]  mem_rmask;
      logic        cop_ack;
      logic [63:0] cop_rdata;
      logic        fun_valid;
      logic [1:0]  fun_unit;
      lsc_func_t   fun_code;
      logic [63:0] dbg_data;
   } lsc_far_state_t;

endpackage

// ---- hdl/lsc_link_if.sv ----
`timescale 1ns/1ps
interface lsc_link_if;
   logic              mem_req;
   logic              mem_wr;
   logic              mem_cached;
   logic              mem_fetch;
   logic [31:0]       mem_addr;
   logic [7:0]        mem_lanes;
   logic [63:0]       mem_wdata;
   logic              mem_ack;
   logic [63:0]       mem_rdata;
   logic [7:0]        mem_rmask;
   logic              cop_req;
   lsc_pkg::lsc_op_t  cop_kind;
   logic [1:0]        cop_unit;
   logic [4:0]        cop_target;
   logic [63:0]       cop_wdata;
   lsc_pkg::lsc_func_t cop_func;
   logic              cop_ack;
   logic [63:0]       cop_rdata;

   modport dev (
      output mem_req, mem_wr, mem_cached, mem_fetch, mem_addr, mem_lanes, mem_wdata,
      output cop_req, cop_kind, cop_unit, cop_target, cop_wdata, cop_func,
      input  mem_ack, mem_rdata, mem_rmask, cop_ack, cop_rdata
   );

   modport far (
      input  mem_req, mem_wr, mem_cached, mem_fetch, mem_addr, mem_lanes, mem_wdata,
      input  cop_req, cop_kind, cop_unit, cop_target, cop_wdata, cop_func,
      output mem_ack, mem_rdata, mem_rmask, cop_ack, cop_rdata
   );
endinterface

// ---- hdl/lsc_far_end.sv ----
`timescale 1ns/1ps
`include "lsc_defs.svh"
module lsc_far_end #(
   parameter int DEPTH = 16,
   parameter int NREG  = 32
) (
   input  wire logic                CLK_I,
   input  wire logic                RST_N_I,
   input  wire logic                CE_I,
   lsc_link_if.far                  LINK,
   input  wire logic [1:0]          DBG_UNIT_I,
   input  wire logic [4:0]          DBG_REG_I,
   output logic      [63:0]         DBG_DATA_O,
   output logic                     FUN_VALID_O,
   output logic      [1:0]          FUN_UNIT_O,
   output lsc_pkg::lsc_func_t       FUN_CODE_O
);
   localparam int IW = $clog2(DEPTH);

   lsc_pkg::lsc_far_state_t q;
   lsc_pkg::lsc_far_state_t d;
   logic [63:0] mem       [DEPTH];
   logic [63:0] cregs     [4][NREG];
   logic [63:0] lane_bits;
   logic [IW-1:0] idx;

   assign idx = LINK.mem_addr[IW+2:3];

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_lane
         assign lane_bits[8*g +: 8] = {8{LINK.mem_lanes[g]}};
      end
   endgenerate

   always_comb begin
      d = q;
      d.mem_ack   = 1'b0;
      d.cop_ack   = 1'b0;
      d.fun_valid = 1'b0;
      d.dbg_data  = cregs[DBG_UNIT_I][DBG_REG_I];
      if (LINK.mem_req && !LINK.mem_wr) begin
         d.mem_ack   = 1'b1;
         d.mem_rdata = mem[idx] & lane_bits;
         d.mem_rmask = LINK.mem_lanes;
      end
      if (LINK.mem_req && LINK.mem_wr) begin
         d.mem_ack = 1'b1;
      end
      if (LINK.cop_req) begin
         d.cop_ack = 1'b1;
         case (LINK.cop_kind)
            lsc_pkg::LSC_OP_CSW: begin
               d.cop_rdata = {32'h0, cregs[LINK.cop_unit][LINK.cop_target][31:0]};
            end
            lsc_pkg::LSC_OP_CSD: begin
               d.cop_rdata = cregs[LINK.cop_unit][LINK.cop_target];
            end
            lsc_pkg::LSC_OP_FUN: begin
               d.fun_valid = 1'b1;
               d.fun_unit  = LINK.cop_unit;
               d.fun_code  = LINK.cop_func;
            end
            default: begin
               d.cop_rdata = q.cop_rdata;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         q <= '0;
      end else if (CE_I) begin
         q <= d;
      end
   end

   // Memory writes touch only the enabled byte lanes.
   always_ff @(posedge CLK_I) begin
      if (CE_I && LINK.mem_req && LINK.mem_wr) begin
         for (int b = 0; b < 8; b++) begin
            if (LINK.mem_lanes[b]) begin
               mem[idx][8*b +: 8] <= LINK.mem_wdata[8*b +: 8];
            end
         end
      end
   end

   // Coprocessor loads store the delivered word or doubleword in the named register.
   always_ff @(posedge CLK_I) begin
      if (CE_I && LINK.cop_req) begin
         if (LINK.cop_kind == lsc_pkg::LSC_OP_CLW) begin
            cregs[LINK.cop_unit][LINK.cop_target] <= {32'h0, LINK.cop_wdata[31:0]};
         end else if (LINK.cop_kind == lsc_pkg::LSC_OP_CLD) begin
            cregs[LINK.cop_unit][LINK.cop_target] <= LINK.cop_wdata;
         end
      end
   end

   // Store words come from the low word or doubleword of the register.
   assign LINK.mem_ack   = q.mem_ack;
   assign LINK.mem_rdata = q.mem_rdata;
   assign LINK.mem_rmask = q.mem_rmask;
   assign LINK.cop_ack   = q.cop_ack;
   assign LINK.cop_rdata = q.cop_rdata;
   assign DBG_DATA_O     = q.dbg_data;
   assign FUN_VALID_O    = q.fun_valid;
   assign FUN_UNIT_O     = q.fun_unit;
   assign FUN_CODE_O     = q.fun_code;
endmodule

// ---- hdl/lsc_dev_end.sv ----
`timescale 1ns/1ps
`include "lsc_defs.svh"
module lsc_dev_end (
   input  wire logic                CLK_I,
   input  wire logic                RST_N_I,
   input  wire logic                CE_I,
   input  wire logic                CMD_VALID_I,
   output logic                     CMD_READY_O,
   input  wire lsc_pkg::lsc_op_t    CMD_OP_I,
   input  wire logic [31:0]         CMD_VIRT_LOCATION_I,
   input  wire logic [2:0]          CMD_TRANSFER_BYTE_COUNT_CODE_I,
   input  wire logic                CMD_BIG_ENDIAN_I,
   input  wire logic                CMD_FETCH_OR_DATA_SELECT_I,
   input  wire logic [1:0]          CMD_UNIT_I,
   input  wire logic [4:0]          CMD_TARGET_REGISTER_SPECIFIER_I,
   input  wire lsc_pkg::lsc_func_t  CMD_FUNC_I,
   input  wire logic [63:0]         CMD_WDATA_I,
   input  wire logic                MAP_VALID_I,
   input  wire logic                MAP_READ_ONLY_I,
   input  wire logic                MAP_CACHED_I,
   input  wire logic [31:0]         MAP_BASE_I,
   input  wire logic [2:0]          ARCH_REVISION_FIELD_I,
   output logic                     DONE_O,
   output logic [63:0]              RDATA_O,
   output logic [7:0]               RMASK_O,
   output logic [1:0]               EXC_O,
   output logic                     UNALIGNED_CAPABILITY_CHECK_O,
   lsc_link_if.dev                  LINK
);
   lsc_pkg::lsc_dev_state_t q;
   lsc_pkg::lsc_dev_state_t d;
   logic [7:0]  len_mask;
   logic [63:0] len_bits;
   logic [63:0] ext_rdata;

   // Byte count mask for the captured length code.
   assign len_mask  = `LSC_ALL_LANES >> (3'h7 - q.len);
   assign ext_rdata = LINK.mem_rdata >> {q.sh, 3'h0};

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_len
         assign len_bits[8*g +: 8] = {8{len_mask[g]}};
      end
   endgenerate

   always_comb begin
      logic [2:0]  off;
      logic [2:0]  xlen;
      logic [3:0]  span;
      logic        wr;
      logic        unmapped;
      logic        xfault;
      logic        exch;
      logic [2:0]  sh;
      logic [7:0]  lanes;
      off      = CMD_VIRT_LOCATION_I[2:0];
      xlen     = CMD_TRANSFER_BYTE_COUNT_CODE_I;
      span     = 4'h0;
      wr       = 1'b0;
      unmapped = 1'b0;
      xfault   = 1'b0;
      exch     = 1'b0;
      sh       = 3'h0;
      lanes    = 8'h00;
      d        = q;
      d.mem_req = 1'b0;
      d.cop_req = 1'b0;
      d.done    = 1'b0;
      d.mis_ok  = (ARCH_REVISION_FIELD_I >= `LSC_ARCH_REV_MISALIGN);
      case (CMD_OP_I)
         lsc_pkg::LSC_OP_CLW, lsc_pkg::LSC_OP_CSW: begin
            xlen = `LSC_LEN_WORD;
            exch = 1'b1;
         end
         lsc_pkg::LSC_OP_CLD, lsc_pkg::LSC_OP_CSD: begin
            xlen = `LSC_LEN_DOUBLE;
            exch = 1'b1;
         end
         default: begin
            xlen = CMD_TRANSFER_BYTE_COUNT_CODE_I;
         end
      endcase
      wr   = (CMD_OP_I == lsc_pkg::LSC_OP_STORE) || (CMD_OP_I == lsc_pkg::LSC_OP_CSW) ||
             (CMD_OP_I == lsc_pkg::LSC_OP_CSD);
      span = {1'b0, off} + {1'b0, xlen};
      // The lowest byte sits at the least significant lane little-endian,
      // and at the most significant lane big-endian.
      sh    = CMD_BIG_ENDIAN_I ? (3'h7 - off - xlen) : off;
      lanes = (`LSC_ALL_LANES >> (3'h7 - xlen)) << sh;
      unmapped = (CMD_VIRT_LOCATION_I[31:30] == `LSC_SEG_UNMAPPED);
      xfault   = !unmapped && (!MAP_VALID_I || (wr && MAP_READ_ONLY_I));
      case (q.fsm)
         lsc_pkg::LSC_ST_IDLE: begin
            if (CMD_VALID_I) begin
               d.op     = CMD_OP_I;
               d.unit   = CMD_UNIT_I;
               d.target = CMD_TARGET_REGISTER_SPECIFIER_I;
               d.len    = xlen;
               d.sh     = sh;
               d.fetch  = CMD_FETCH_OR_DATA_SELECT_I;
               d.exc    = `LSC_EXC_NONE;
               d.rdata  = 64'h0;
               d.rmask  = 8'h00;
               if (unmapped) begin
                  d.paddr  = {3'h0, CMD_VIRT_LOCATION_I[28:0]};
                  d.cached = !CMD_VIRT_LOCATION_I[29];
               end else begin
                  d.paddr  = MAP_BASE_I + CMD_VIRT_LOCATION_I;
                  d.cached = MAP_CACHED_I;
               end
               // Cached loads fetch the whole element, uncached only the bytes asked for.
               d.lanes = (!wr && d.cached) ? `LSC_ALL_LANES : lanes;
               d.wdata = CMD_WDATA_I << {sh, 3'h0};
               if (CMD_OP_I == lsc_pkg::LSC_OP_FUN) begin
                  d.cop_req  = 1'b1;
                  d.cop_kind = lsc_pkg::LSC_OP_FUN;
                  d.func     = CMD_FUNC_I;
                  d.fsm      = lsc_pkg::LSC_ST_COPPUT;
               end else if (exch && CMD_UNIT_I == `LSC_UNIT_SYSCTL) begin
                  d.exc  = `LSC_EXC_UNIT;
                  d.done = 1'b1;
                  d.fsm  = lsc_pkg::LSC_ST_DONE;
               end else if (xfault) begin
                  d.exc  = `LSC_EXC_XLATE;
                  d.done = 1'b1;
                  d.fsm  = lsc_pkg::LSC_ST_DONE;
               end else if (span > `LSC_LANE_LAST) begin
                  d.exc  = `LSC_EXC_MISALIGN;
                  d.done = 1'b1;
                  d.fsm  = lsc_pkg::LSC_ST_DONE;
               end else if (CMD_OP_I == lsc_pkg::LSC_OP_CSW ||
                            CMD_OP_I == lsc_pkg::LSC_OP_CSD) begin
                  d.cop_req  = 1'b1;
                  d.cop_kind = CMD_OP_I;
                  d.fsm      = lsc_pkg::LSC_ST_COPGET;
               end else begin
                  d.mem_req = 1'b1;
                  d.mem_wr  = wr;
                  d.fsm     = lsc_pkg::LSC_ST_MEMACC;
               end
            end
         end
         lsc_pkg::LSC_ST_COPGET: begin
            if (LINK.cop_ack) begin
               d.wdata   = (LINK.cop_rdata & len_bits) << {q.sh, 3'h0};
               d.mem_req = 1'b1;
               d.mem_wr  = 1'b1;
               d.fsm     = lsc_pkg::LSC_ST_MEMACC;
            end
         end
         lsc_pkg::LSC_ST_MEMACC: begin
            if (LINK.mem_ack) begin
               if (q.mem_wr) begin
                  d.done = 1'b1;
                  d.fsm  = lsc_pkg::LSC_ST_DONE;
               end else begin
                  d.rdata = ext_rdata & len_bits;
                  d.rmask = (LINK.mem_rmask >> q.sh) & len_mask;
                  if (q.op == lsc_pkg::LSC_OP_CLW || q.op == lsc_pkg::LSC_OP_CLD) begin
                     d.cop_wdata = ext_rdata & len_bits;
                     d.cop_kind  = q.op;
                     d.cop_req   = 1'b1;
                     d.fsm       = lsc_pkg::LSC_ST_COPPUT;
                  end else begin
                     d.done = 1'b1;
                     d.fsm  = lsc_pkg::LSC_ST_DONE;
                  end
               end
            end
         end
         lsc_pkg::LSC_ST_COPPUT: begin
            if (LINK.cop_ack) begin
               d.done = 1'b1;
               d.fsm  = lsc_pkg::LSC_ST_DONE;
            end
         end
         lsc_pkg::LSC_ST_DONE: begin
            d.fsm = lsc_pkg::LSC_ST_IDLE;
         end
         default: begin
            d.fsm = lsc_pkg::LSC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         q <= '0;
      end else if (CE_I) begin
         q <= d;
      end
   end

   assign CMD_READY_O = (q.fsm == lsc_pkg::LSC_ST_IDLE);
   assign DONE_O      = q.done;
   assign RDATA_O     = q.rdata;
   assign RMASK_O     = q.rmask;
   assign EXC_O       = q.exc;
   assign UNALIGNED_CAPABILITY_CHECK_O = q.mis_ok;

   // The element address is aligned; lanes pick the bytes inside it.
   assign LINK.mem_req    = q.mem_req;
   assign LINK.mem_wr     = q.mem_wr;
   assign LINK.mem_cached = q.cached;
   assign LINK.mem_fetch  = q.fetch;
   assign LINK.mem_addr   = {q.paddr[31:3], 3'h0};
   assign LINK.mem_lanes  = q.lanes;
   assign LINK.mem_wdata  = q.wdata;
   assign LINK.cop_req    = q.cop_req;
   assign LINK.cop_kind   = q.cop_kind;
   assign LINK.cop_unit   = q.unit;
   assign LINK.cop_target = q.target;
   assign LINK.cop_wdata  = q.cop_wdata;
   assign LINK.cop_func   = q.func;
endmodule

// ---- sim/lsc_checker.sv ----
`timescale 1ns/1ps
module lsc_checker (
   input wire logic             CLK_I,
   input wire logic             RST_N_I,
   input wire logic             mem_req,
   input wire logic             mem_wr,
   input wire logic             mem_cached,
   input wire logic [31:0]      mem_addr,
   input wire logic [7:0]       mem_lanes,
   input wire logic             mem_ack,
   input wire logic [7:0]       mem_rmask,
   input wire logic             cop_req,
   input wire lsc_pkg::lsc_op_t cop_kind,
   input wire logic [1:0]       cop_unit,
   input wire logic [63:0]      cop_wdata,
   input wire logic             cop_ack,
   input wire logic [63:0]      cop_rdata
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   property p_aligned;
      mem_req |-> mem_addr[2:0] == 3'h0;
   endproperty
   a_aligned: assert property (p_aligned)
      else $error("element address not aligned");
   property p_cached_full;
      mem_req && !mem_wr && mem_cached |-> mem_lanes == 8'hFF;
   endproperty
   a_cached_full: assert property (p_cached_full)
      else $error("cached read not whole element");
   property p_rmask;
      mem_ack && !$past(mem_wr) |-> mem_rmask == $past(mem_lanes);
   endproperty
   a_rmask: assert property (p_rmask)
      else $error("valid bytes differ from requested lanes");
   property p_lanes_run;
      mem_req |-> mem_lanes != 8'h00
         && ((mem_lanes + (mem_lanes & (~mem_lanes + 8'h01))) & mem_lanes) == 8'h00;
   endproperty
   a_lanes_run: assert property (p_lanes_run)
      else $error("lanes empty or not contiguous");
   property p_no_sysctl;
      cop_req && cop_kind != lsc_pkg::LSC_OP_FUN |-> cop_unit != 2'h0;
   endproperty
   a_no_sysctl: assert property (p_no_sysctl)
      else $error("register exchange with unit zero");
   property p_word_in;
      cop_req && cop_kind == lsc_pkg::LSC_OP_CLW |-> cop_wdata[63:32] == 32'h0;
   endproperty
   a_word_in: assert property (p_word_in)
      else $error("word load wider than 32 bits");
   property p_word_out;
      cop_ack && $past(cop_kind) == lsc_pkg::LSC_OP_CSW |-> cop_rdata[63:32] == 32'h0;
   endproperty
   a_word_out: assert property (p_word_out)
      else $error("word store value wider than 32 bits");
   property p_dstore;
      cop_ack && $past(cop_req) && $past(cop_kind) == lsc_pkg::LSC_OP_CSD
         |=> mem_req && mem_wr && mem_lanes == 8'hFF;
   endproperty
   a_dstore: assert property (p_dstore)
      else $error("doubleword store not written as eight bytes");
   property p_wstore;
      cop_ack && $past(cop_req) && $past(cop_kind) == lsc_pkg::LSC_OP_CSW
         |=> mem_req && mem_wr && $countones(mem_lanes) == 4;
   endproperty
   a_wstore: assert property (p_wstore)
      else $error("word store not written as four bytes");
endmodule

// ---- sim/tb_load_store_coproc_transfer.sv ----
`timescale 1ns/1ps
module tb_load_store_coproc_transfer;
   logic               clk, rst_n, vld, be, fs, mv, mro, mc;
   logic               rdy, done, uok, fv;
   lsc_pkg::lsc_op_t   op;
   lsc_pkg::lsc_func_t fn, fc;
   logic [31:0]        va, a;
   logic [2:0]         ln, ar;
   logic [1:0]         un, du, ex, fu;
   logic [4:0]         tg, dr;
   logic [63:0]        wd, rd, dd;
   logic [7:0]         rm;
   logic [63:0]        mem [16];
   logic [63:0]        creg [4][32];
   logic [2:0]         tops [4] = '{3'h5, 3'h4, 3'h0, 3'h3};
   int                 fails, n_checks, nfun, k;

   lsc_link_if lnk();
   lsc_dev_end u_lsc_dev_end (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .CMD_VALID_I(vld),
      .CMD_READY_O(rdy), .CMD_OP_I(op), .CMD_VIRT_LOCATION_I(va),
      .CMD_TRANSFER_BYTE_COUNT_CODE_I(ln), .CMD_BIG_ENDIAN_I(be),
      .CMD_FETCH_OR_DATA_SELECT_I(fs), .CMD_UNIT_I(un), .CMD_TARGET_REGISTER_SPECIFIER_I(tg),
      .CMD_FUNC_I(fn), .CMD_WDATA_I(wd), .MAP_VALID_I(mv), .MAP_READ_ONLY_I(mro),
      .MAP_CACHED_I(mc), .MAP_BASE_I(32'h0), .ARCH_REVISION_FIELD_I(ar), .DONE_O(done),
      .RDATA_O(rd), .RMASK_O(rm), .EXC_O(ex), .UNALIGNED_CAPABILITY_CHECK_O(uok), .LINK(lnk));
   lsc_far_end u_lsc_far_end (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .LINK(lnk),
      .DBG_UNIT_I(du), .DBG_REG_I(dr), .DBG_DATA_O(dd), .FUN_VALID_O(fv), .FUN_UNIT_O(fu),
      .FUN_CODE_O(fc));
   lsc_checker u_chk (.CLK_I(clk), .RST_N_I(rst_n), .mem_req(lnk.mem_req),
      .mem_wr(lnk.mem_wr), .mem_cached(lnk.mem_cached), .mem_addr(lnk.mem_addr),
      .mem_lanes(lnk.mem_lanes), .mem_ack(lnk.mem_ack), .mem_rmask(lnk.mem_rmask),
      .cop_req(lnk.cop_req), .cop_kind(lnk.cop_kind), .cop_unit(lnk.cop_unit),
      .cop_wdata(lnk.cop_wdata), .cop_ack(lnk.cop_ack), .cop_rdata(lnk.cop_rdata));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) if (fv === 1'b1) nfun++;

   function automatic logic [7:0] lanes(input logic [2:0] o, l, input logic b);
      logic [7:0] m;
      m = 8'hFF >> (3'h7 - l);
      return b ? m << (3'h7 - o - l) : m << o;
   endfunction

   function automatic logic [63:0] ext(input logic [63:0] e, input logic [7:0] m);
      logic [63:0] r;
      int          j;
      r = 64'h0;
      j = 0;
      for (int i = 0; i < 8; i++) if (m[i]) begin
         r[8*j+:8] = e[8*i+:8];
         j++;
      end
      return r;
   endfunction

   function automatic logic [63:0] ins(input logic [63:0] e, w, input logic [7:0] m);
      int j;
      j = 0;
      for (int i = 0; i < 8; i++) if (m[i]) begin
         e[8*i+:8] = w[8*j+:8];
         j++;
      end
      return e;
   endfunction

   task automatic chk(input logic [63:0] g, e, input string s);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value t=%0t %s got %h exp %h", $time, s, g, e);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic peek(input logic [1:0] u, input logic [4:0] t);
      @(posedge clk);
      du <= u;
      dr <= t;
      repeat (2) @(posedge clk);
      #1 chk(dd, creg[u][t], "coprocessor register");
   endtask

   task automatic go(input lsc_pkg::lsc_op_t o, input logic [31:0] a, input logic [2:0] l,
                     input logic b, input logic [1:0] u, input logic [4:0] t,
                     input logic [63:0] w);
      logic [2:0] el;
      logic [7:0] m;
      logic [1:0] xe;
      logic       v, ro, c, mp, wr, cp;
      int         n0;
      v = ($urandom % 6) != 0;
      ro = ($urandom % 3) == 0;
      c = 1'($urandom);
      cp = o >= lsc_pkg::LSC_OP_CLW && o <= lsc_pkg::LSC_OP_CSD;
      wr = o inside {lsc_pkg::LSC_OP_STORE, lsc_pkg::LSC_OP_CSW, lsc_pkg::LSC_OP_CSD};
      el = !cp ? l : (o == lsc_pkg::LSC_OP_CLW || o == lsc_pkg::LSC_OP_CSW) ? 3'h3 : 3'h7;
      mp = a[31:30] != 2'h2;
      m = lanes(a[2:0], el, b);
      xe = (cp && u == 2'h0) ? 2'h3 : (mp && (!v || (ro && wr))) ? 2'h1 :
           ({1'b0, a[2:0]} + {1'b0, el} > 4'h7) ? 2'h2 : 2'h0;
      if (o == lsc_pkg::LSC_OP_FUN) xe = 2'h0;
      n0 = nfun;
      @(posedge clk);
      vld <= 1'b1;
      op <= o;
      va <= a;
      ln <= l;
      be <= b;
      un <= u;
      tg <= t;
      wd <= w;
      fn <= 25'($urandom);
      fs <= 1'($urandom);
      mv <= v;
      mro <= ro;
      mc <= c;
      @(posedge clk);
      vld <= 1'b0;
      k = 0;
      #1;
      while (done !== 1'b1 && k < 20) begin
         @(posedge clk);
         #1 k++;
      end
      chk(64'(k < 20), 64'h1, "no completion");
      chk(64'(rdy), 64'h0, "ready while finishing");
      chk(64'(ex), 64'(xe), "fault code");
      if (xe == 2'h0) case (o)
         lsc_pkg::LSC_OP_LOAD: begin
            chk(rd, ext(mem[a[6:3]], m), "load data");
            if (!(mp ? c : !a[29])) chk(64'(rm), 64'(8'hFF >> (3'h7 - el)), "mask");
         end
         lsc_pkg::LSC_OP_STORE: mem[a[6:3]] = ins(mem[a[6:3]], w, m);
         lsc_pkg::LSC_OP_CLW, lsc_pkg::LSC_OP_CLD: begin
            creg[u][t] = ext(mem[a[6:3]], m);
            chk(rd, creg[u][t], "coprocessor load data");
            peek(u, t);
         end
         lsc_pkg::LSC_OP_FUN: begin
            chk(64'(fu), 64'(u), "function unit");
            chk(64'(fc), 64'(fn), "function code");
            chk(64'(nfun), 64'(n0 + 1), "function count");
         end
         default: mem[a[6:3]] = ins(mem[a[6:3]], creg[u][t], m);
      endcase
   endtask

   // The whole run needs under 4000 cycles; the limit of 40000 allows over ten times that.
   initial begin
      #200us;
      fails++;
      results();
   end

   initial begin
      rst_n = 1'b0;
      {vld, be, fs, mv, mro, mc, va, ln, ar, un, du, tg, dr, fn, wd} = '0;
      op = lsc_pkg::LSC_OP_LOAD;
      fails = 0;
      n_checks = 0;
      nfun = 0;
      k = $urandom(32'h8406);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         ar <= 3'(i);
         repeat (2) @(posedge clk);
         #1 chk(64'(uok), 64'(i >= 2), "misaligned support flag");
      end
      for (int i = 0; i < 16; i++)
         go(lsc_pkg::LSC_OP_STORE, 32'hA000_0000 | 32'(i * 8), 3'h7, 1'b0, 2'h0, 5'h0,
            {$urandom, $urandom});
      for (int u = 1; u < 4; u++) for (int t = 0; t < 32; t++)
         go(lsc_pkg::LSC_OP_CLD, 32'h8000_0000 | 32'(t * 8), 3'h0, 1'(t), 2'(u), 5'(t), 64'h0);
      for (int l = 0; l < 8; l++) for (int b = 0; b < 2; b++) begin
         go(lsc_pkg::LSC_OP_LOAD, 32'hA000_0000 + 32'(7 - l), 3'(l), 1'(b), 2'h0, 5'h0, 64'h0);
         go(lsc_pkg::LSC_OP_LOAD, 32'hA000_0010 + 32'(8 - l), 3'(l), 1'(b), 2'h0, 5'h0, 64'h0);
      end
      repeat (500) begin
         a = {tops[$urandom % 4], 22'h0, 7'($urandom)};
         go(lsc_pkg::lsc_op_t'(3'($urandom % 7)), a, 3'($urandom), 1'($urandom),
            2'($urandom), 5'($urandom), {$urandom, $urandom});
      end
      results();
   end
endmodule
